// *** design/mec_expansion.sv ***
// memory expansion paging, chip selects, stretch and E clock output
`timescale 1ns/10ps
`default_nettype none

module mec_expansion (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        expanded_mode,
	input  wire logic [15:0] cpu_addr,
	input  wire logic        cycle_req,
	input  wire logic        cycle_internal,
	output logic             cycle_ready,
	output logic             cycle_done,
	input  wire logic [4:0]  register_block,
	input  wire logic        extra_window_location_select,
	input  wire logic        extra_window_enable,
	input  wire logic        data_window_enable,
	input  wire logic        program_window_enable,
	input  wire logic [7:0]  extra_page_register,
	input  wire logic [7:0]  data_page_register,
	input  wire logic [7:0]  program_page_register,
	input  wire logic [5:0]  expansion_pin_assign,
	input  wire logic [5:0]  expansion_port_direction,
	input  wire logic [5:0]  expansion_port_data,
	input  wire logic        sel_enable_wr,
	input  wire logic [6:0]  sel_enable_wdata,
	output logic      [6:0]  sel_enable_state,
	input  wire logic        peripheral_select_three_follows_extra,
	input  wire logic        data_space_select_full,
	input  wire logic        program_select_one_full,
	input  wire logic [13:0] sel_stretch,
	input  wire logic        stretched_e_clock_choice,
	input  wire logic        internal_visibility,
	input  wire logic        e_clock_output_disable,
	output logic      [15:0] addr_out,
	output logic             addr_oe_n,
	output logic      [5:0]  exp_addr_out,
	output logic      [5:0]  exp_addr_oe_n,
	output logic      [6:0]  chip_select_n,
	output logic      [6:0]  chip_select_oe_n,
	output logic             e_clock_out
);

	mec_pkg::mec_regs_t r_reg;
	mec_pkg::mec_regs_t r_next;

	logic [11:0] xaddr;
	logic        extra_hit;
	logic [6:0]  hit;
	logic [1:0]  hit_stretch;
	logic        finish;

	// paging windows on the live cpu address
	mec_window_xlate u_xlate (
		.addr       (cpu_addr),
		.loc_sel    (extra_window_location_select),
		.extra_en   (extra_window_enable),
		.data_en    (data_window_enable),
		.prog_en    (program_window_enable),
		.extra_page (extra_page_register),
		.data_page  (data_page_register),
		.prog_page  (program_page_register),
		.xaddr      (xaddr),
		.extra_hit  (extra_hit)
	);

	// chip select decode on the same address as the translation
	mec_select_decode u_decode (
		.addr        (cpu_addr),
		.reg_block   (register_block),
		.sel_en      (r_reg.sel_en),
		.sel3_follow (peripheral_select_three_follows_extra),
		.extra_hit   (extra_hit),
		.data_full   (data_space_select_full),
		.prog1_full  (program_select_one_full),
		.stretch_cfg (sel_stretch),
		.hit         (hit),
		.stretch     (hit_stretch)
	);

	// a new cycle is taken only from idle
	assign cycle_ready = (r_reg.state == mec_pkg::ST_IDLE);

	// bus cycle sequencer and pin staging
	always_comb
	begin
		r_next = r_reg;
		r_next.done = 1'b0;
		finish = 1'b0;

		if (sel_enable_wr)
		begin
			r_next.sel_en = sel_enable_wdata;
		end

		case (r_reg.state)
			mec_pkg::ST_IDLE:
			begin
				if (cycle_req)
				begin
					r_next.state = mec_pkg::ST_LOW;
					// address and selects captured together
					r_next.xaddr = xaddr;
					r_next.addr_lo = cpu_addr[9:0];
					r_next.hide_e = cycle_internal && !internal_visibility;
					if (expanded_mode && !cycle_internal)
					begin
						r_next.sel_n = ~hit;
						r_next.stretch = hit_stretch;
					end
					else
					begin
						r_next.sel_n = mec_pkg::SEL_IDLE;
						r_next.stretch = 2'h0;
					end
				end
			end
			mec_pkg::ST_LOW:
			begin
				r_next.state = mec_pkg::ST_HIGH;
			end
			mec_pkg::ST_HIGH:
			begin
				if (r_reg.stretch == 2'h0)
				begin
					finish = 1'b1;
				end
				else
				begin
					// two clocks per added bus cycle
					r_next.state = mec_pkg::ST_STRETCH;
					r_next.cnt = 3'(r_reg.stretch * mec_pkg::CLKS_PER_BUS_CYCLE - 3'h1);
				end
			end
			mec_pkg::ST_STRETCH:
			begin
				if (r_reg.cnt == 3'h0)
				begin
					finish = 1'b1;
				end
				else
				begin
					r_next.cnt = r_reg.cnt - 3'h1;
				end
			end
			default:
			begin
				finish = 1'b1;
			end
		endcase

		// select held through every stretch clock, dropped at the end
		if (finish)
		begin
			r_next.state = mec_pkg::ST_IDLE;
			r_next.done = 1'b1;
			r_next.sel_n = mec_pkg::SEL_IDLE;
			r_next.hide_e = 1'b0;
		end

		// plain E keeps its rhythm, stretched E holds high while stretching
		case (r_next.state)
			mec_pkg::ST_LOW:
			begin
				r_next.e_plain = 1'b0;
				r_next.e_stretch = 1'b0;
			end
			mec_pkg::ST_HIGH:
			begin
				r_next.e_plain = 1'b1;
				r_next.e_stretch = 1'b1;
			end
			mec_pkg::ST_STRETCH:
			begin
				r_next.e_plain = ~r_reg.e_plain;
				r_next.e_stretch = 1'b1;
			end
			default:
			begin
				r_next.e_plain = ~r_reg.e_plain;
				r_next.e_stretch = ~r_reg.e_stretch;
			end
		endcase

		// upper six lines: address when assigned in expanded mode, else port
		for (int i = 0; i < 6; i++)
		begin
			if (expanded_mode && expansion_pin_assign[i])
			begin
				r_next.exp_out[i] = r_next.xaddr[6+i];
				r_next.exp_oe_n[i] = 1'b0;
			end
			else
			begin
				r_next.exp_out[i] = expansion_port_data[i];
				r_next.exp_oe_n[i] = ~expansion_port_direction[i];
			end
		end

		// lines 15..0 and enabled selects driven only in expanded mode
		r_next.addr_oe_n = ~expanded_mode;
		r_next.sel_oe_n = expanded_mode ? ~r_next.sel_en : mec_pkg::SEL_IDLE;
	end

	// single state register
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			r_reg.state <= mec_pkg::ST_IDLE;
			r_reg.stretch <= 2'h0;
			r_reg.cnt <= 3'h0;
			r_reg.xaddr <= mec_pkg::XADDR_RESET;
			r_reg.addr_lo <= mec_pkg::ADDR_LO_RESET;
			r_reg.sel_en <= mec_pkg::SEL_ENABLE_RESET;
			r_reg.sel_n <= mec_pkg::SEL_IDLE;
			r_reg.sel_oe_n <= mec_pkg::SEL_IDLE;
			r_reg.exp_out <= 6'h00;
			r_reg.exp_oe_n <= mec_pkg::PIN_RELEASED;
			r_reg.addr_oe_n <= 1'b1;
			r_reg.e_plain <= 1'b0;
			r_reg.e_stretch <= 1'b0;
			r_reg.hide_e <= 1'b0;
			r_reg.done <= 1'b0;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	// pin outputs straight from the state register
	assign addr_out = {r_reg.xaddr[5:0], r_reg.addr_lo};
	assign addr_oe_n = r_reg.addr_oe_n;
	assign exp_addr_out = r_reg.exp_out;
	assign exp_addr_oe_n = r_reg.exp_oe_n;
	assign chip_select_n = r_reg.sel_n;
	assign chip_select_oe_n = r_reg.sel_oe_n;
	assign sel_enable_state = r_reg.sel_en;
	assign cycle_done = r_reg.done;

	// E pin: disabled, hidden internal cycle, stretched or plain
	always_comb
	begin
		if (e_clock_output_disable || r_reg.hide_e)
			e_clock_out = 1'b0;
		else if (stretched_e_clock_choice)
			e_clock_out = r_reg.e_stretch;
		else
			e_clock_out = r_reg.e_plain;
	end

endmodule : mec_expansion

`default_nettype wire

// *** design/mec_pkg.sv ***
// package: constants and state types for the memory expansion and chip select block
package mec_pkg;

	// window location tags on the internal address
	localparam logic [5:0] EXTRA_BLK_LOWEST = 6'h00;
	localparam logic [5:0] EXTRA_BLK_NEXT   = 6'h01;
	localparam logic [3:0] DATA_WIN_TAG     = 4'h7;
	localparam logic [1:0] PROG_WIN_TAG     = 2'h2;

	// forced-high expansion lines
	localparam logic [5:0] EXP_LINES_HIGH = 6'h3f;
	localparam logic [3:0] EXTRA_FORCE    = 4'hf;
	localparam logic [1:0] DATA_FORCE     = 2'h3;

	// peripheral select slots inside the register 2-Kbyte block
	localparam logic [1:0] PERIPH_HALF_TAG = 2'h1;
	localparam logic [3:0] SEL3_SLOT       = 4'h5;
	localparam logic [3:0] SEL2_SLOT       = 4'h7;
	localparam logic [2:0] SEL1_SLOT       = 3'h3;

	// chip select indices
	localparam int SEL_PERIPH0 = 0;
	localparam int SEL_PERIPH1 = 1;
	localparam int SEL_PERIPH2 = 2;
	localparam int SEL_PERIPH3 = 3;
	localparam int SEL_DATA    = 4;
	localparam int SEL_PROG0   = 5;
	localparam int SEL_PROG1   = 6;
	localparam int NUM_SELECTS = 7;

	// values after reset
	localparam logic [6:0]  SEL_ENABLE_RESET = 7'h20;
	localparam logic [6:0]  SEL_IDLE         = 7'h7f;
	localparam logic [5:0]  PIN_RELEASED     = 6'h3f;
	localparam logic [11:0] XADDR_RESET      = 12'hfc0;
	localparam logic [9:0]  ADDR_LO_RESET    = 10'h000;

	// clocks per stretch bus cycle
	localparam logic [2:0] CLKS_PER_BUS_CYCLE = 3'h2;

	typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_STRETCH} mec_state_t;

	typedef struct packed {
		mec_state_t  state;
		logic [1:0]  stretch;
		logic [2:0]  cnt;
		logic [11:0] xaddr;
		logic [9:0]  addr_lo;
		logic [6:0]  sel_en;
		logic [6:0]  sel_n;
		logic [6:0]  sel_oe_n;
		logic [5:0]  exp_out;
		logic [5:0]  exp_oe_n;
		logic        addr_oe_n;
		logic        e_plain;
		logic        e_stretch;
		logic        hide_e;
		logic        done;
	} mec_regs_t;

endpackage : mec_pkg

// *** design/mec_select_decode.sv ***
// chip select address decode and stretch pick
`timescale 1ns/10ps
`default_nettype none

module mec_select_decode (
	input  wire logic [15:0] addr,
	input  wire logic [4:0]  reg_block,
	input  wire logic [6:0]  sel_en,
	input  wire logic        sel3_follow,
	input  wire logic        extra_hit,
	input  wire logic        data_full,
	input  wire logic        prog1_full,
	input  wire logic [13:0] stretch_cfg,
	output logic      [6:0]  hit,
	output logic      [1:0]  stretch
);

	logic in_periph;

	// the 512 bytes just above the register space
	assign in_periph = (addr[15:11] == reg_block) && (addr[10:9] == mec_pkg::PERIPH_HALF_TAG);

	// peripheral selects first, memory selects fill the rest
	always_comb
	begin
		hit = '0;
		if (sel3_follow && extra_hit && sel_en[mec_pkg::SEL_PERIPH3])
		begin
			hit[mec_pkg::SEL_PERIPH3] = 1'b1;
		end
		if (in_periph)
		begin
			if (!sel3_follow && sel_en[mec_pkg::SEL_PERIPH3] && addr[10:7] == mec_pkg::SEL3_SLOT)
				hit[mec_pkg::SEL_PERIPH3] = 1'b1;
			else if (sel_en[mec_pkg::SEL_PERIPH2] && addr[10:7] == mec_pkg::SEL2_SLOT)
				hit[mec_pkg::SEL_PERIPH2] = 1'b1;
			else if (sel_en[mec_pkg::SEL_PERIPH1] && addr[10:8] == mec_pkg::SEL1_SLOT)
				hit[mec_pkg::SEL_PERIPH1] = 1'b1;
			else if (sel_en[mec_pkg::SEL_PERIPH0])
				hit[mec_pkg::SEL_PERIPH0] = 1'b1;
		end
		if (hit[3:0] == 4'h0)
		begin
			if (sel_en[mec_pkg::SEL_DATA] &&
				(data_full ? !addr[15] : addr[15:12] == mec_pkg::DATA_WIN_TAG))
				hit[mec_pkg::SEL_DATA] = 1'b1;
			if (sel_en[mec_pkg::SEL_PROG0] && addr[15])
				hit[mec_pkg::SEL_PROG0] = 1'b1;
			if (sel_en[mec_pkg::SEL_PROG1] && (prog1_full || addr[15]))
				hit[mec_pkg::SEL_PROG1] = 1'b1;
		end
	end

	// lowest-numbered active select sets the stretch
	always_comb
	begin
		stretch = 2'h0;
		for (int i = mec_pkg::NUM_SELECTS - 1; i >= 0; i--)
		begin
			if (hit[i])
				stretch = stretch_cfg[2*i +: 2];
		end
	end

endmodule : mec_select_decode

`default_nettype wire

// *** design/mec_window_xlate.sv ***
// window translation of the internal address into the 22-bit external address
`timescale 1ns/10ps
`default_nettype none

module mec_window_xlate (
	input  wire logic [15:0] addr,
	input  wire logic        loc_sel,
	input  wire logic        extra_en,
	input  wire logic        data_en,
	input  wire logic        prog_en,
	input  wire logic [7:0]  extra_page,
	input  wire logic [7:0]  data_page,
	input  wire logic [7:0]  prog_page,
	output logic      [11:0] xaddr,
	output logic             extra_hit
);

	// extra window sits at the lowest or the next 1-Kbyte block
	assign extra_hit = extra_en && (addr[15:10] ==
		(loc_sel ? mec_pkg::EXTRA_BLK_LOWEST : mec_pkg::EXTRA_BLK_NEXT));

	// xaddr holds lines 21..10; outside a window upper six lines read high
	always_comb
	begin
		xaddr = {mec_pkg::EXP_LINES_HIGH, addr[15:10]};
		if (extra_hit)
		begin
			xaddr = {mec_pkg::EXTRA_FORCE, extra_page};
		end
		else if (data_en && addr[15:12] == mec_pkg::DATA_WIN_TAG)
		begin
			xaddr = {mec_pkg::DATA_FORCE, data_page, addr[11:10]};
		end
		else if (prog_en && addr[15:14] == mec_pkg::PROG_WIN_TAG)
		begin
			xaddr = {prog_page, addr[13:10]};
		end
	end

endmodule : mec_window_xlate

`default_nettype wire

// *** tb/mec_expansion_monitor.sv ***
// checker of pin timing for the expansion block
`timescale 1ns/10ps
`default_nettype none
module mec_expansion_monitor (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        expanded_mode,
	input wire logic [15:0] cpu_addr,
	input wire logic        cycle_req,
	input wire logic        cycle_ready,
	input wire logic        cycle_done,
	input wire logic [5:0]  expansion_pin_assign,
	input wire logic [5:0]  expansion_port_direction,
	input wire logic [5:0]  expansion_port_data,
	input wire logic        e_clock_output_disable,
	input wire logic [15:0] addr_out,
	input wire logic        addr_oe_n,
	input wire logic [5:0]  exp_addr_out,
	input wire logic [5:0]  exp_addr_oe_n,
	input wire logic [6:0]  chip_select_n,
	input wire logic [6:0]  chip_select_oe_n,
	input wire logic        e_clock_out
);
	logic       take;
	logic [9:0] low_reg;
	logic [9:0] low_next;

	// low address bits captured when a cycle is taken
	assign take     = cycle_req && cycle_ready;
	assign low_next = take ? cpu_addr[9:0] : low_reg;
	always_ff @(posedge clk)
	begin
		low_reg <= low_next;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_low_bits;
		cycle_done && !addr_oe_n |-> addr_out[9:0] == low_reg;
	endproperty
	a_low_bits: assert property (p_low_bits) else $error("low address bits differ");

	property p_cycle_len;
		take |-> ##1 !cycle_done [*2] ##[1:7] cycle_done;
	endproperty
	a_cycle_len: assert property (p_cycle_len) else $error("cycle length out of range");

	property p_sel_idle;
		cycle_done |-> chip_select_n == 7'h7f;
	endproperty
	a_sel_idle: assert property (p_sel_idle) else $error("select held past cycle end");

	property p_hold;
		!cycle_ready && !$past(cycle_ready) |-> $stable(chip_select_n) && $stable(addr_out);
	endproperty
	a_hold: assert property (p_hold) else $error("select or address moved mid cycle");

	property p_single;
		!expanded_mode && !$past(expanded_mode) |-> chip_select_oe_n == 7'h7f && addr_oe_n;
	endproperty
	a_single: assert property (p_single) else $error("pins driven in single chip mode");

	property p_gpio;
		!$past(rst) && !$past(expanded_mode) |-> exp_addr_oe_n == ~$past(expansion_port_direction)
			&& exp_addr_out == $past(expansion_port_data);
	endproperty
	a_gpio: assert property (p_gpio) else $error("upper pins not plain io");

	property p_assign;
		!$past(rst) && $past(expanded_mode) |-> !addr_oe_n
			&& exp_addr_oe_n == ~($past(expansion_pin_assign) | $past(expansion_port_direction));
	endproperty
	a_assign: assert property (p_assign) else $error("pin assignment not honoured");

	property p_e_off;
		e_clock_output_disable && $past(e_clock_output_disable) |-> !e_clock_out;
	endproperty
	a_e_off: assert property (p_e_off) else $error("e clock not held off");
endmodule : mec_expansion_monitor

bind mec_expansion mec_expansion_monitor u_mon (.clk, .rst, .expanded_mode, .cpu_addr, .cycle_req, .cycle_ready,
	.cycle_done, .expansion_pin_assign, .expansion_port_direction, .expansion_port_data, .e_clock_output_disable,
	.addr_out, .addr_oe_n, .exp_addr_out, .exp_addr_oe_n, .chip_select_n, .chip_select_oe_n, .e_clock_out);
`default_nettype wire

// *** tb/mec_ext_dev.sv ***
// external device stub latching the address it is selected with
`timescale 1ns/10ps
`default_nettype none
module mec_ext_dev (
	input wire logic        clk,
	input wire logic [6:0]  chip_select_n,
	input wire logic [21:0] bus_addr,
	output logic     [21:0] seen_addr
);
	// device takes the address only while one of its selects is low
	always_ff @(posedge clk)
	begin
		if (!(&chip_select_n))
			seen_addr <= bus_addr;
	end
endmodule : mec_ext_dev
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the expansion block
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk = 1'b0, rst = 1'b1, expanded_mode = 1'b1, cycle_req = 1'b0, cycle_internal = 1'b0;
	logic        extra_window_location_select = 1'b1, extra_window_enable = 1'b1, data_window_enable = 1'b1;
	logic        program_window_enable = 1'b1, sel_enable_wr = 1'b0, peripheral_select_three_follows_extra = 1'b1;
	logic        data_space_select_full = 1'b0, program_select_one_full = 1'b0, stretched_e_clock_choice = 1'b1;
	logic        internal_visibility = 1'b1, e_clock_output_disable = 1'b0;
	logic        cycle_ready, cycle_done, addr_oe_n, e_clock_out, rd;
	logic [4:0]  register_block = 5'h01;
	logic [5:0]  expansion_pin_assign = 6'h3f, expansion_port_direction = 6'h00, expansion_port_data = 6'h00;
	logic [5:0]  exp_addr_out, exp_addr_oe_n;
	logic [6:0]  sel_enable_wdata = 7'h00, sel_enable_state, chip_select_n, chip_select_oe_n, sel;
	logic [7:0]  extra_page_register = 8'ha5, data_page_register = 8'h3c, program_page_register = 8'h96;
	logic [13:0] sel_stretch = 14'h24e4;
	logic [15:0] cpu_addr = 16'h0000, addr_out;
	logic [21:0] seen_addr;
	logic [9:0]  ev;
	int          mismatches = 0, checked = 0;

	mec_expansion DUT (.clk, .rst, .expanded_mode, .cpu_addr, .cycle_req, .cycle_internal, .cycle_ready, .cycle_done,
		.register_block, .extra_window_location_select, .extra_window_enable, .data_window_enable,
		.program_window_enable, .extra_page_register, .data_page_register, .program_page_register,
		.expansion_pin_assign, .expansion_port_direction, .expansion_port_data, .sel_enable_wr, .sel_enable_wdata,
		.sel_enable_state, .peripheral_select_three_follows_extra, .data_space_select_full, .program_select_one_full,
		.sel_stretch, .stretched_e_clock_choice, .internal_visibility, .e_clock_output_disable, .addr_out,
		.addr_oe_n, .exp_addr_out, .exp_addr_oe_n, .chip_select_n, .chip_select_oe_n, .e_clock_out);

	mec_ext_dev u_dev (.clk, .chip_select_n, .bus_addr({exp_addr_out, addr_out}), .seen_addr);

	// 50 MHz clock
	always #10 clk = ~clk;

	task chk(input logic [21:0] g, input logic [21:0] e, input string m);
		checked = checked + 1;
		if (g !== e)
		begin
			mismatches = mismatches + 1;
			$display("BAD %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk

	// one bus cycle: length, selects, pin address and device view
	task run(input logic [15:0] a, input logic in, input logic [21:0] ea, input logic [6:0] es, input logic [21:0] ec);
		logic [21:0] n;
		n = 22'h0;
		ev = 10'h0;
		cpu_addr = a;
		cycle_internal = in;
		cycle_req = 1'b1;
		@(posedge clk) #1;
		cycle_req = 1'b0;
		while (cycle_done !== 1'b1 && n < 22'd20)
		begin
			@(posedge clk) #1;
			n = n + 22'h1;
			ev = {ev[8:0], e_clock_out};
			if (n == 22'h1)
			begin
				sel = chip_select_n;
				rd = cycle_ready;
			end
		end
		chk(n, ec, "cycle length");
		chk({20'h0, rd, cycle_ready}, 22'h1, "ready");
		chk({15'h0, sel}, {15'h0, es}, "selects");
		if (expanded_mode)
			chk({exp_addr_out, addr_out}, ea, "address");
		if (es != 7'h7f)
			chk(seen_addr, ea, "device address");
	endtask : run

	task wr_en(input logic [6:0] v);
		sel_enable_wdata = v;
		sel_enable_wr = 1'b1;
		@(posedge clk) #1;
		sel_enable_wr = 1'b0;
	endtask : wr_en

	task end_of_test;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	// main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b0;
		chk({addr_oe_n, chip_select_oe_n, chip_select_n, sel_enable_state}, {1'b1, 7'h7f, 7'h7f, 7'h20}, "reset");
		wr_en(7'h7f);
		run(16'h0123, 1'b0, 22'h3e9523, 7'h77, 22'h8);
		run(16'h0523, 1'b0, 22'h3f0523, 7'h7f, 22'h2);
		run(16'h7abc, 1'b0, 22'h33cabc, 7'h6f, 22'h2);
		run(16'h9234, 1'b0, 22'h259234, 7'h1f, 22'h4);
		run(16'hc001, 1'b0, 22'h3fc001, 7'h1f, 22'h4);
		extra_window_location_select = 1'b0;
		run(16'h0523, 1'b0, 22'h3e9523, 7'h77, 22'h8);
		extra_window_enable = 1'b0;
		data_window_enable = 1'b0;
		program_window_enable = 1'b0;
		run(16'h7abc, 1'b0, 22'h3f7abc, 7'h6f, 22'h2);
		run(16'h9234, 1'b0, 22'h3f9234, 7'h1f, 22'h4);
		$display("test paging done");
		run(16'h0a10, 1'b0, 22'h3f0a10, 7'h7e, 22'h2);
		run(16'h0b10, 1'b0, 22'h3f0b10, 7'h7d, 22'h4);
		chk({18'h0, ev[4:1]}, 22'h7, "stretched e");
		stretched_e_clock_choice = 1'b0;
		run(16'h0b10, 1'b0, 22'h3f0b10, 7'h7d, 22'h4);
		chk({18'h0, ev[4:1]}, 22'h5, "plain e");
		run(16'h0b90, 1'b0, 22'h3f0b90, 7'h7b, 22'h6);
		peripheral_select_three_follows_extra = 1'b0;
		run(16'h0a90, 1'b0, 22'h3f0a90, 7'h77, 22'h8);
		data_space_select_full = 1'b1;
		run(16'h2000, 1'b0, 22'h3f2000, 7'h6f, 22'h2);
		data_space_select_full = 1'b0;
		program_select_one_full = 1'b1;
		run(16'h2000, 1'b0, 22'h3f2000, 7'h3f, 22'h6);
		// select three alone on the lowest block, upper pins left as io
		extra_window_location_select = 1'b1;
		extra_page_register = 8'h00;
		expansion_pin_assign = 6'h00;
		extra_window_enable = 1'b1;
		peripheral_select_three_follows_extra = 1'b1;
		run(16'h0123, 1'b0, 22'h000123, 7'h77, 22'h8);
		expansion_pin_assign = 6'h3f;
		internal_visibility = 1'b0;
		run(16'h0a10, 1'b1, 22'h3f0a10, 7'h7f, 22'h2);
		chk({20'h0, ev[2:1]}, 22'h0, "internal e");
		$display("test selects done");
		wr_en(7'h00);
		run(16'hc001, 1'b0, 22'h3fc001, 7'h7f, 22'h2);
		chk({8'h0, sel_enable_state, chip_select_oe_n}, {8'h0, 7'h00, 7'h7f}, "enables off");
		wr_en(7'h7f);
		expansion_pin_assign = 6'h0f;
		expansion_port_direction = 6'h10;
		e_clock_output_disable = 1'b1;
		run(16'hc001, 1'b0, 22'h0fc001, 7'h1f, 22'h4);
		chk({10'h0, ev, exp_addr_oe_n == 6'h20, addr_oe_n}, 22'h2, "pins and e off");
		expanded_mode = 1'b0;
		expansion_port_data = 6'h2a;
		expansion_port_direction = 6'h15;
		run(16'h9234, 1'b0, 22'h0, 7'h7f, 22'h2);
		chk({2'b0, addr_oe_n, chip_select_oe_n, exp_addr_oe_n, exp_addr_out}, {3'h1, 7'h7f, 6'h2a, 6'h2a}, "single");
		$display("test pins done");
		end_of_test();
	end

	// watchdog against a hung handshake
	initial
	begin
		#100000;
		mismatches = mismatches + 1;
		end_of_test();
	end
endmodule : tb
`default_nettype wire
